// [rtl/tsm_pkg.sv]
// constants, field layouts and mode codes of the timer slave-mode trigger control block
//
// Overview of operation
// - outputs off: ch1 output takes its idle level
// - outputs off: ch1 complement output takes idle level
// - ch2 idle level bit behaves like ch1
// - idle level writes ignored while write lock set
// - mode 000: plain internal counting when running
// - modes 001-011: quadrature encoder counting on inputs
// - mode 100: trigger rise resets counter, update
// - mode 101: count only while trigger high
// - mode 110: trigger rise starts the counter
// - mode 111: trigger rising edges clock the counter
// - trigger source select picks one of eight
// - master/slave synchronisation enable bit provided
package tsm_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] TSM_OFS_RUN_CTRL = 8'h00;
  localparam logic [7:0] TSM_OFS_IDLE_CTRL = 8'h04;
  localparam logic [7:0] TSM_OFS_SLAVE_CTRL = 8'h08;
  localparam logic [7:0] TSM_OFS_STATUS = 8'h20;

  // field positions
  localparam int TSM_RUN_POS = 0;
  localparam int TSM_CH1_IDLE_POS = 8;
  localparam int TSM_CH1C_IDLE_POS = 9;
  localparam int TSM_CH2_IDLE_POS = 10;
  localparam int TSM_SMF_LSB = 0;
  localparam int TSM_TSEL_LSB = 4;
  localparam int TSM_MSM_POS = 7;
  localparam int TSM_STS_TRIG_POS = 16;
  localparam int TSM_STS_RUN_POS = 17;

  // reset values
  localparam logic [15:0] TSM_CNT_RST = 16'h0000;
  localparam logic        TSM_BIT_RST = 1'b0;
  localparam logic [31:0] TSM_DATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    TSM_SM_OFF    = 3'h0,
    TSM_SM_ENC1   = 3'h1,
    TSM_SM_ENC2   = 3'h2,
    TSM_SM_ENC3   = 3'h3,
    TSM_SM_RESET  = 3'h4,
    TSM_SM_GATED  = 3'h5,
    TSM_SM_TRIG   = 3'h6,
    TSM_SM_EXTCLK = 3'h7
  } tsm_smode_t;

  typedef enum logic [2:0] {
    TSM_TS_INTERNAL_TRIGGER_ZERO   = 3'h0,
    TSM_TS_INTERNAL_TRIGGER_ONE   = 3'h1,
    TSM_TS_INTERNAL_TRIGGER_TWO   = 3'h2,
    TSM_TS_INTERNAL_TRIGGER_THREE   = 3'h3,
    TSM_TS_CH1ED  = 3'h4,
    TSM_TS_CH1F   = 3'h5,
    TSM_TS_CH2F   = 3'h6,
    TSM_TS_EXT    = 3'h7
  } tsm_tsel_t;

endpackage

// [rtl/tsm_reg_if.sv]
// register-file to core carrier of the timer slave-mode block
`timescale 1ns/1ps
interface tsm_reg_if;
  import tsm_pkg::*;
  logic        counter_run;
  tsm_smode_t  slave_function_select;
  tsm_tsel_t   trigger_source_select;
  logic        sync_master_enable;
  logic        ch1_idle_level;
  logic        ch1_comp_idle_level;
  logic        ch2_idle_level;
  logic        run_set;
  logic [15:0] count;
  logic        trig_level;

  modport regs (
    output counter_run, slave_function_select, trigger_source_select, sync_master_enable,
    output ch1_idle_level, ch1_comp_idle_level, ch2_idle_level,
    input  run_set, count, trig_level
  );
  modport core (
    input  counter_run, slave_function_select, trigger_source_select, sync_master_enable,
    input  ch1_idle_level, ch1_comp_idle_level, ch2_idle_level,
    output run_set, count, trig_level
  );
endinterface

// [rtl/tsm_sync.sv]
// two-flop synchroniser, parameterised width
`timescale 1ns/1ps
module tsm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // clock
  input  wire logic         rst_n,  // async reset, active low
  input  wire logic [W-1:0] d,      // asynchronous levels
  output logic      [W-1:0] q       // synchronised levels
);
  logic [W-1:0] stage1;

  // stage1 is read only by q
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      q      <= '0;
    end
    else
    begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule // tsm_sync

// [rtl/tsm_regs.sv]
// apb register file of the timer slave-mode block
`timescale 1ns/1ps
module tsm_regs
  import tsm_pkg::*;
(
  input  wire logic        pclk,             // clock
  input  wire logic        presetn,          // async reset, active low
  input  wire logic [7:0]  paddr,            // byte address
  input  wire logic        psel,             // select
  input  wire logic        penable,          // access phase
  input  wire logic        pwrite,           // 1 write
  input  wire logic [31:0] pwdata,           // write data
  output logic      [31:0] prdata,           // read data
  output logic             pready,           // transfer done
  output logic             pslverr,          // unmapped address
  input  wire logic [1:0]  write_lock_level, // lock level from break unit
  tsm_reg_if.regs          rif               // to core
);
  logic        hit;
  logic [31:0] rd_mux;
  logic        wr;

  always_comb
  begin
    hit    = 1'b1;
    rd_mux = TSM_DATA_RST;
    case (paddr)
      TSM_OFS_RUN_CTRL:   rd_mux[TSM_RUN_POS] = rif.counter_run;
      TSM_OFS_IDLE_CTRL:
      begin
        rd_mux[TSM_CH1_IDLE_POS]  = rif.ch1_idle_level;
        rd_mux[TSM_CH1C_IDLE_POS] = rif.ch1_comp_idle_level;
        rd_mux[TSM_CH2_IDLE_POS]  = rif.ch2_idle_level;
      end
      TSM_OFS_SLAVE_CTRL:
      begin
        rd_mux[TSM_SMF_LSB +: 3]  = rif.slave_function_select;
        rd_mux[TSM_TSEL_LSB +: 3] = rif.trigger_source_select;
        rd_mux[TSM_MSM_POS]       = rif.sync_master_enable;
      end
      TSM_OFS_STATUS:
      begin
        rd_mux[15:0]             = rif.count;
        rd_mux[TSM_STS_TRIG_POS] = rif.trig_level;
        rd_mux[TSM_STS_RUN_POS]  = rif.counter_run;
      end
      default:            hit = 1'b0;
    endcase
  end

  assign wr = psel && penable && pready && pwrite && hit;

  // one wait state; data and error settle with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= TSM_DATA_RST;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_mux : TSM_DATA_RST;
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  // hardware start wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rif.counter_run <= TSM_BIT_RST;
    else if (rif.run_set)
      rif.counter_run <= 1'b1;
    else if (wr && paddr == TSM_OFS_RUN_CTRL)
      rif.counter_run <= pwdata[TSM_RUN_POS];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rif.ch1_idle_level      <= TSM_BIT_RST;
      rif.ch1_comp_idle_level <= TSM_BIT_RST;
      rif.ch2_idle_level      <= TSM_BIT_RST;
    end
    else if (wr && paddr == TSM_OFS_IDLE_CTRL && write_lock_level == 2'h0)
    begin
      rif.ch1_idle_level      <= pwdata[TSM_CH1_IDLE_POS];
      rif.ch1_comp_idle_level <= pwdata[TSM_CH1C_IDLE_POS];
      rif.ch2_idle_level      <= pwdata[TSM_CH2_IDLE_POS];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rif.slave_function_select <= TSM_SM_OFF;
      rif.trigger_source_select <= TSM_TS_INTERNAL_TRIGGER_ZERO;
      rif.sync_master_enable    <= TSM_BIT_RST;
    end
    else if (wr && paddr == TSM_OFS_SLAVE_CTRL)
    begin
      rif.slave_function_select <= tsm_smode_t'(pwdata[TSM_SMF_LSB +: 3]);
      rif.trigger_source_select <= tsm_tsel_t'(pwdata[TSM_TSEL_LSB +: 3]);
      rif.sync_master_enable    <= pwdata[TSM_MSM_POS];
    end
  end

  property p_idle_lock;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == TSM_OFS_IDLE_CTRL && write_lock_level != 2'h0)
      |=> $stable({rif.ch1_idle_level, rif.ch1_comp_idle_level, rif.ch2_idle_level});
  endproperty
  a_idle_lock: assert property (p_idle_lock) else $error("idle level changed under lock");

  property p_msm_write;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == TSM_OFS_SLAVE_CTRL) |=> rif.sync_master_enable == $past(pwdata[TSM_MSM_POS]);
  endproperty
  a_msm_write: assert property (p_msm_write) else $error("sync enable not written");

endmodule // tsm_regs

// [rtl/tsm_top.sv]
// timer slave-mode and trigger selection logic with channel idle levels
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module tsm_top
  import tsm_pkg::*;
(
  input  wire logic        pclk,                   // 250 mhz clock
  input  wire logic        presetn,                // async reset, active low
  input  wire logic [7:0]  paddr,                  // apb byte address
  input  wire logic        psel,                   // apb select
  input  wire logic        penable,                // apb access phase
  input  wire logic        pwrite,                 // apb direction
  input  wire logic [31:0] pwdata,                 // apb write data
  output logic      [31:0] prdata,                 // apb read data
  output logic             pready,                 // apb ready
  output logic             pslverr,                // apb error
  input  wire logic        internal_trigger_zero,  // trigger from another timer
  input  wire logic        internal_trigger_one,   // trigger from another timer
  input  wire logic        internal_trigger_two,   // trigger from another timer
  input  wire logic        internal_trigger_three, // trigger from another timer
  input  wire logic        ch1_edge_detect,        // ch1 edge detector
  input  wire logic        ch1_filtered_input,     // ch1 filtered input
  input  wire logic        ch2_filtered_input,     // ch2 filtered input
  input  wire logic        ext_trigger_filtered,   // filtered external trigger
  input  wire logic        main_output_enable,     // main output enable
  input  wire logic [1:0]  write_lock_level,       // write lock level
  input  wire logic        ch1_active,             // ch1 level after dead time
  input  wire logic        ch1_comp_active,        // ch1 complement after dead time
  input  wire logic        ch2_active,             // ch2 level after dead time
  output logic             ch1_output,             // ch1 pin level
  output logic             ch1_comp_output,        // ch1 complement pin level
  output logic             ch2_output,             // ch2 pin level
  output logic      [15:0] count_value,            // counter value
  output logic             update_event,           // register update pulse
  output logic             selected_trigger_input, // synchronised trigger level
  output logic             sync_master_enable      // master/slave sync enable
);
  tsm_reg_if rif ();

  logic       trig_raw;
  logic       trig_s;
  logic       trig_d;
  logic       trig_rise;
  logic [1:0] enc_s;
  logic [1:0] enc_d;
  logic       ch1_edge;
  logic       ch2_edge;
  logic       ch1_up;
  logic       ch2_up;
  logic [15:0] next_count;
  logic        next_update;
  logic        next_run_set;
  logic [15:0] count;

  tsm_regs u_regs (
    .pclk             (pclk),
    .presetn          (presetn),
    .paddr            (paddr),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .write_lock_level (write_lock_level),
    .rif              (rif)
  );

  // source mux; switching it with slave mode on can fake an edge
  always_comb
  begin
    case (rif.trigger_source_select)
      TSM_TS_INTERNAL_TRIGGER_ZERO:  trig_raw = internal_trigger_zero;
      TSM_TS_INTERNAL_TRIGGER_ONE:  trig_raw = internal_trigger_one;
      TSM_TS_INTERNAL_TRIGGER_TWO:  trig_raw = internal_trigger_two;
      TSM_TS_INTERNAL_TRIGGER_THREE:  trig_raw = internal_trigger_three;
      TSM_TS_CH1ED: trig_raw = ch1_edge_detect;
      TSM_TS_CH1F:  trig_raw = ch1_filtered_input;
      TSM_TS_CH2F:  trig_raw = ch2_filtered_input;
      TSM_TS_EXT:   trig_raw = ext_trigger_filtered;
      default:      trig_raw = 1'b0;
    endcase
  end

  // other timers may run on other clocks, so sync before edge detection
  tsm_sync #(.W(1)) u_trig_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (trig_raw),
    .q     (trig_s)
  );

  tsm_sync #(.W(2)) u_enc_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({ch2_filtered_input, ch1_filtered_input}),
    .q     (enc_s)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_d <= 1'b0;
      enc_d  <= 2'h0;
    end
    else
    begin
      trig_d <= trig_s;
      enc_d  <= enc_s;
    end
  end

  assign trig_rise = trig_s && !trig_d;
  assign ch1_edge  = enc_s[0] ^ enc_d[0];
  assign ch2_edge  = enc_s[1] ^ enc_d[1];
  // quadrature: ch1 leading ch2 counts up
  assign ch1_up    = enc_s[0] != enc_s[1];
  assign ch2_up    = enc_s[1] == enc_s[0];

  always_comb
  begin
    next_count   = count;
    next_update  = 1'b0;
    next_run_set = 1'b0;
    case (rif.slave_function_select)
      TSM_SM_OFF:
        if (rif.counter_run)
          next_count = count + 16'h0001;
      TSM_SM_ENC1:
        if (rif.counter_run && ch2_edge)
          next_count = ch2_up ? count + 16'h0001 : count - 16'h0001;
      TSM_SM_ENC2:
        if (rif.counter_run && ch1_edge)
          next_count = ch1_up ? count + 16'h0001 : count - 16'h0001;
      TSM_SM_ENC3:
        // simultaneous edges on both inputs are illegal quadrature; hold
        if (rif.counter_run && (ch1_edge ^ ch2_edge))
        begin
          if (ch1_edge)
            next_count = ch1_up ? count + 16'h0001 : count - 16'h0001;
          else
            next_count = ch2_up ? count + 16'h0001 : count - 16'h0001;
        end
      TSM_SM_RESET:
        if (trig_rise)
        begin
          next_count  = TSM_CNT_RST;
          next_update = 1'b1;
        end
        else if (rif.counter_run)
          next_count = count + 16'h0001;
      TSM_SM_GATED:
        if (rif.counter_run && trig_s)
          next_count = count + 16'h0001;
      TSM_SM_TRIG:
      begin
        next_run_set = trig_rise && !rif.counter_run;
        if (rif.counter_run)
          next_count = count + 16'h0001;
      end
      TSM_SM_EXTCLK:
        if (rif.counter_run && trig_rise)
          next_count = count + 16'h0001;
      default:
        next_count = count;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count        <= TSM_CNT_RST;
      update_event <= 1'b0;
      rif.run_set  <= 1'b0;
    end
    else
    begin
      count        <= next_count;
      update_event <= next_update;
      rif.run_set  <= next_run_set;
    end
  end

  assign rif.count      = count;
  assign rif.trig_level = trig_s;

  // idle levels apply only while the main outputs are off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch1_output      <= TSM_BIT_RST;
      ch1_comp_output <= TSM_BIT_RST;
      ch2_output      <= TSM_BIT_RST;
    end
    else
    begin
      ch1_output      <= main_output_enable ? ch1_active : rif.ch1_idle_level;
      ch1_comp_output <= main_output_enable ? ch1_comp_active : rif.ch1_comp_idle_level;
      ch2_output      <= main_output_enable ? ch2_active : rif.ch2_idle_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_value            <= TSM_CNT_RST;
      selected_trigger_input <= 1'b0;
      sync_master_enable     <= TSM_BIT_RST;
    end
    else
    begin
      count_value            <= count;
      selected_trigger_input <= trig_s;
      sync_master_enable     <= rif.sync_master_enable;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_idle_ch1;
    !main_output_enable |=> ch1_output == $past(rif.ch1_idle_level);
  endproperty
  a_idle_ch1: assert property (p_idle_ch1) else $error("ch1 not at idle level");

  property p_idle_ch1c;
    !main_output_enable |=> ch1_comp_output == $past(rif.ch1_comp_idle_level);
  endproperty
  a_idle_ch1c: assert property (p_idle_ch1c) else $error("ch1 comp not at idle");

  property p_idle_ch2;
    !main_output_enable |=> ch2_output == $past(rif.ch2_idle_level);
  endproperty
  a_idle_ch2: assert property (p_idle_ch2) else $error("ch2 not at idle level");

  property p_free_count;
    (rif.slave_function_select == TSM_SM_OFF && rif.counter_run)
      |=> ##1 count_value == $past(count_value) + 16'h0001;
  endproperty
  a_free_count: assert property (p_free_count) else $error("free count missed");

  property p_enc1_hold;
    (rif.slave_function_select == TSM_SM_ENC1 && !ch2_edge) |=> $stable(count);
  endproperty
  a_enc1_hold: assert property (p_enc1_hold) else $error("encoder counted without edge");

  sequence s_reset_trig;
    rif.slave_function_select == TSM_SM_RESET && trig_rise;
  endsequence
  property p_reset_mode;
    s_reset_trig |=> count == TSM_CNT_RST && update_event ##1 count_value == TSM_CNT_RST;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset mode missed trigger");

  property p_gated_hold;
    (rif.slave_function_select == TSM_SM_GATED && !trig_s) |=> $stable(count);
  endproperty
  a_gated_hold: assert property (p_gated_hold) else $error("gated mode counted while low");

  sequence s_start;
    rif.slave_function_select == TSM_SM_TRIG && trig_rise && !rif.counter_run;
  endsequence
  sequence s_running;
    rif.run_set ##1 rif.counter_run;
  endsequence
  property p_trig_start;
    s_start |=> s_running;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

  property p_extclk;
    (rif.slave_function_select == TSM_SM_EXTCLK && !trig_rise) |=> $stable(count);
  endproperty
  a_extclk: assert property (p_extclk) else $error("external clock counted without edge");

  property p_ext_select;
    (rif.trigger_source_select == TSM_TS_EXT && ext_trigger_filtered)[*3]
      |=> selected_trigger_input;
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("external trigger not selected");

  // a one-cycle trigger pulse must still show on the output one cycle after its edge
  property p_single_rise;
    trig_rise |=> !trig_rise && selected_trigger_input;
  endproperty
  a_single_rise: assert property (p_single_rise) else $error("edge seen twice");

  property p_gated_count;
    (rif.slave_function_select == TSM_SM_GATED && rif.counter_run && trig_s)
      |=> count == $past(count) + 16'h0001;
  endproperty
  a_gated_count: assert property (p_gated_count) else $error("gated count missed");

  property p_trig_wait;
    (rif.slave_function_select == TSM_SM_TRIG && !rif.counter_run) |=> $stable(count);
  endproperty
  a_trig_wait: assert property (p_trig_wait) else $error("counted before start");

  property p_extclk_step;
    (rif.slave_function_select == TSM_SM_EXTCLK && rif.counter_run && trig_rise)
      |=> count == $past(count) + 16'h0001;
  endproperty
  a_extclk_step: assert property (p_extclk_step) else $error("clock edge lost");

endmodule // tsm_top

// [bench/tsm_trig_src.sv]
// model of the neighbouring timers that supply the internal trigger lines
`timescale 1ns/1ps
module tsm_trig_src (
  input  wire logic       pclk,    // clock
  input  wire logic       presetn, // async reset, active low
  input  wire logic [3:0] want,    // trigger levels asked for by the bench
  input  wire logic [3:0] lag,     // cycles of delay, 0 answers promptly
  output logic      [3:0] itr      // trigger lines into the block
);
  logic [15:0][3:0] hist;

  // a master timer changes its trigger only from its own clocked logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hist <= '0;
    else
      hist <= {hist[14:0], want};
  end

  assign itr = (lag == 4'h0) ? want : hist[lag - 4'h1];
endmodule // tsm_trig_src

// [bench/tb_timer_slave_mode_trigger_control.sv]
// self-checking bench of the timer slave-mode trigger control block
`timescale 1ns/1ps
module tb_timer_slave_mode_trigger_control;
  import tsm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  want, lag, itr;
  logic ch1_edge_detect, ch1_filtered_input, ch2_filtered_input, ext_trigger_filtered;
  logic main_output_enable, ch1_active, ch1_comp_active, ch2_active;
  logic ch1_output, ch1_comp_output, ch2_output, update_event;
  logic selected_trigger_input, sync_master_enable, e, seen;
  logic [1:0]  write_lock_level;
  logic [15:0] count_value, a, b;
  int n_mismatch = 0;
  int compares = 0;

  tsm_trig_src u_src (.pclk, .presetn, .want, .lag, .itr);
  tsm_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .internal_trigger_zero(itr[0]), .internal_trigger_one(itr[1]),
    .internal_trigger_two(itr[2]), .internal_trigger_three(itr[3]), .ch1_edge_detect,
    .ch1_filtered_input, .ch2_filtered_input, .ext_trigger_filtered, .main_output_enable,
    .write_lock_level, .ch1_active, .ch1_comp_active, .ch2_active, .ch1_output,
    .ch1_comp_output, .ch2_output, .count_value, .update_event, .selected_trigger_input,
    .sync_master_enable);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task print_verdict;
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(k), 32'd2, "apb answer");
  endtask

  task rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(r, exp, "register read");
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task put_src(input logic [7:0] v);
    @(posedge pclk);
    want <= v[3:0];
    ch1_edge_detect <= v[4];
    ch1_filtered_input <= v[5];
    ch2_filtered_input <= v[6];
    ext_trigger_filtered <= v[7];
  endtask

  // source is only changed while slave mode is off
  task set_mode(input logic [2:0] ts, input logic [2:0] sm);
    apb(1'b1, TSM_OFS_SLAVE_CTRL, {25'h0, ts, 4'h0});
    apb(1'b1, TSM_OFS_SLAVE_CTRL, {25'h0, ts, 1'b0, sm});
  endtask

  task span(input int n, input logic [15:0] exp, input string msg);
    settle(1);
    a = count_value;
    settle(n);
    b = count_value;
    chk(32'(b - a), 32'(exp), msg);
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    print_verdict;
  end

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {want, lag, write_lock_level} = '0;
    {ch1_edge_detect, ch1_filtered_input, ch2_filtered_input, ext_trigger_filtered} = '0;
    {main_output_enable, ch1_active, ch1_comp_active, ch2_active} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(TSM_OFS_RUN_CTRL, 32'h0);
    rd(TSM_OFS_IDLE_CTRL, 32'h0);
    rd(TSM_OFS_SLAVE_CTRL, 32'h0);
    apb(1'b1, TSM_OFS_SLAVE_CTRL, 32'h80);
    rd(TSM_OFS_SLAVE_CTRL, 32'h80);
    chk(32'(sync_master_enable), 32'h1, "sync enable pin");
    apb(1'b1, TSM_OFS_SLAVE_CTRL, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk({e, r[30:0]}, 32'h8000_0000, "unmapped read");
    // idle levels with outputs off, actives set opposite
    {ch1_active, ch1_comp_active, ch2_active} <= 3'b010;
    apb(1'b1, TSM_OFS_IDLE_CTRL, 32'h500);
    settle(3);
    chk({ch1_output, ch1_comp_output, ch2_output}, 3'b101, "idle outputs");
    for (int l = 1; l < 4; l++)
    begin
      write_lock_level <= 2'(l);
      apb(1'b1, TSM_OFS_IDLE_CTRL, 32'h200);
      rd(TSM_OFS_IDLE_CTRL, 32'h500);
    end
    write_lock_level <= 2'h0;
    apb(1'b1, TSM_OFS_IDLE_CTRL, 32'h200);
    settle(3);
    chk({ch1_output, ch1_comp_output, ch2_output}, 3'b010, "idle outputs");
    main_output_enable <= 1'b1;
    {ch1_active, ch1_comp_active, ch2_active} <= 3'b101;
    settle(3);
    chk({ch1_output, ch1_comp_output, ch2_output}, 3'b101, "driven outputs");
    // each source alone high, then alone low
    for (int t = 0; t < 8; t++)
    begin
      set_mode(3'(t), 3'h0);
      put_src(8'h1 << t);
      settle(6);
      chk(32'(selected_trigger_input), 32'h1, "source high");
      put_src(~(8'h1 << t));
      settle(6);
      chk(32'(selected_trigger_input), 32'h0, "source low");
    end
    put_src(8'h0);
    set_mode(3'h7, 3'h0);
    apb(1'b1, TSM_OFS_RUN_CTRL, 32'h1);
    span(10, 16'd10, "free count");
    apb(1'b1, TSM_OFS_RUN_CTRL, 32'h0);
    span(10, 16'd0, "stopped count");
    apb(1'b1, TSM_OFS_RUN_CTRL, 32'h1);
    set_mode(3'h7, 3'h5);
    span(10, 16'd0, "gate low");
    put_src(8'h80);
    settle(5);
    span(10, 16'd10, "gate high");
    put_src(8'h0);
    settle(5);
    span(10, 16'd0, "gate low again");
    set_mode(3'h7, 3'h7);
    settle(5);
    a = count_value;
    for (int p = 0; p < 5; p++)
    begin
      put_src(8'h80);
      settle(6);
      put_src(8'h0);
      settle(6);
    end
    chk(32'(count_value - a), 32'd5, "trigger clocked count");
    set_mode(3'h7, 3'h4);
    settle(20);
    put_src(8'h80);
    seen = 1'b0;
    for (int k = 0; k < 20 && !seen; k++)
    begin
      settle(1);
      seen = update_event;
    end
    chk(32'(seen), 32'h1, "update pulse");
    // count_value trails the internal counter by one cycle
    settle(1);
    chk(32'(count_value), 32'h0, "counter cleared");
    put_src(8'h0);
    apb(1'b1, TSM_OFS_RUN_CTRL, 32'h0);
    set_mode(3'h1, 3'h6);
    rd(TSM_OFS_SLAVE_CTRL, 32'h16);
    span(10, 16'd0, "waiting for start");
    lag <= 4'h5;
    put_src(8'h2);
    seen = 1'b0;
    for (int k = 0; k < 30 && !seen; k++)
    begin
      apb(1'b0, TSM_OFS_STATUS, 32'h0);
      seen = r[TSM_STS_RUN_POS];
    end
    chk(32'(seen), 32'h1, "started by trigger");
    span(10, 16'd10, "count after start");
    put_src(8'h0);
    for (int m = 1; m < 4; m++)
    begin
      set_mode(3'h0, 3'(m));
      apb(1'b1, TSM_OFS_RUN_CTRL, 32'h1);
      settle(6);
      a = count_value;
      for (int i = 0; i < 8; i++)
        put_src({1'b0, 1'(i % 4 == 1 || i % 4 == 2), 1'(i % 4 < 2), 5'h0});
      put_src(8'h0);
      settle(8);
      chk(32'(count_value - a), (m == 3) ? 32'd8 : 32'd4, "encoder count");
    end
    print_verdict;
  end
endmodule // tb_timer_slave_mode_trigger_control
